// ### logic/fdr_defines.vh
// Register offsets, reset values, field positions and timing for the fan/thermal bank
// Functional notes
// R1: Each current-duty register maps 0x00 to zero duty and 0xff to full duty linearly.
// R2: Current-duty registers reset to 0xff so fans start at full duty.
// R3: In automatic mode the current-duty registers follow the control loop duty.
// R4: While a fan is starting up its current-duty register reads 0x00.
// R5: In manual mode a host write to a current-duty register sets that fan's duty.
// R6: The first thermal reading register is read-only, shows the client value, resets to 0x80.
// R7: Bit 0 of a configuration input selects two's complement or offset-64 coding.
// R8: In two's complement coding a diode fault shows as 0x80 in the reading.
// R9: In offset-64 coding a diode fault shows as 0x00 in the reading.
// R10: The reading updates once per smoothing interval of reads times (bit time x 67 x CPUs + 14 us).
// R11: The smoothing field codes 000..110 select 16..65536 reads; 111 is reserved.
// R12: The domain-count bit says whether the first CPU has one (0) or two (1) domains.
// R13: With the swap bit set the first remote reading and first thermal reading are exchanged.
// R14: In swap mode the related limit and fan-control registers are exchanged too; the bank leaves them unswapped and only outputs swap_active.
// R15: Once the lock bit is set the thermal configuration register ignores writes.
// R16: Three ceiling registers, reset 0xff, cap each fan's duty.
// R17: In automatic mode a host write does not alter the driven duty.
`ifndef FDR_DEFINES_VH
`define FDR_DEFINES_VH

`define FDR_A_DUTY1 8'h30
`define FDR_A_DUTY2 8'h31
`define FDR_A_DUTY3 8'h32
`define FDR_A_READ0 8'h33
`define FDR_A_LOLIM 8'h34
`define FDR_A_HILIM 8'h35
`define FDR_A_CFG 8'h36
`define FDR_A_CEIL1 8'h38
`define FDR_A_CEIL2 8'h39
`define FDR_A_CEIL3 8'h3a

`define FDR_RST_DUTY 8'hff
`define FDR_RST_READ 8'h80
`define FDR_RST_LOLIM 8'h81
`define FDR_RST_HILIM 8'h00
`define FDR_RST_CFG 8'h00
`define FDR_RST_CEIL 8'hff
`define FDR_ZERO8 8'h00
`define FDR_FAULT_TWOS 8'h80
`define FDR_FAULT_OFS 8'h00
`define FDR_CFG_WMASK 8'h1f

`define FDR_CFG_SMOOTH_HI 2
`define FDR_CFG_SMOOTH_LO 0
`define FDR_CFG_DOM 3
`define FDR_CFG_SWAP 4
`define FDR_SMOOTH_RSVD 3'h7

`define FDR_CLK_MHZ 10
`define FDR_IDLE_US 14
`define FDR_IDLE_CYC (`FDR_IDLE_US * `FDR_CLK_MHZ)
`define FDR_BITS_PER_READ 67
`define FDR_SMOOTH_LOG0 4
`define FDR_SMOOTH_LOG1 11

`endif

// ### logic/fdr_duty_chan.v
// One fan channel: current duty register, ceiling register, driven duty
`timescale 1ns/1ps
`include "fdr_defines.vh"
module fdr_duty_chan (
    core_clk,
    rst_n,
    auto_mode,
    startup,
    loop_duty,
    wr_duty,
    wr_ceil,
    wdata,
    duty_rd,
    ceil_rd,
    duty_out
);
    input wire core_clk;
    input wire rst_n;
    input wire auto_mode;
    input wire startup;
    input wire [7:0] loop_duty;
    input wire wr_duty;
    input wire wr_ceil;
    input wire [7:0] wdata;
    output wire [7:0] duty_rd;
    output wire [7:0] ceil_rd;
    output reg [7:0] duty_out;

    reg [7:0] duty_r;
    reg [7:0] ceil_r;
    reg [7:0] duty_nxt;
    wire [7:0] capped;

    always @* begin
        duty_nxt = duty_r;
        // R3: follow loop
        if (auto_mode) begin
            duty_nxt = loop_duty;
        // R5: manual write
        end else if (wr_duty) begin
            duty_nxt = wdata;
        end
        // R17: auto ignores write (handled by priority above)
    end

    // R16: ceiling caps duty
    assign capped = (duty_r > ceil_r) ? ceil_r : duty_r;
    // R4: startup reads zero
    assign duty_rd = startup ? `FDR_ZERO8 : duty_r;
    assign ceil_rd = ceil_r;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            // R2: full duty at reset
            duty_r <= `FDR_RST_DUTY;
            ceil_r <= `FDR_RST_CEIL;
            duty_out <= `FDR_RST_DUTY;
        end else begin
            duty_r <= duty_nxt;
            if (wr_ceil) begin
                ceil_r <= wdata;
            end
            // R1: linear 8-bit duty code, capped by the ceiling register, passed to the PWM
            duty_out <= capped;
        end
    end
endmodule

// ### logic/fdr_sync2.v
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
module fdr_sync2 (
    core_clk,
    rst_n,
    din,
    dout
);
    input wire core_clk;
    input wire rst_n;
    input wire din;
    output reg dout;

    reg meta_r;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

// ### logic/fdr_regs.v
// Fan duty and CPU thermal register bank with smoothing-interval update
`timescale 1ns/1ps
`include "fdr_defines.vh"
module fdr_regs (
    core_clk,
    rst_n,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    lock_bit,
    offset64_sel,
    auto_mode,
    fan_startup,
    loop_duty1,
    loop_duty2,
    loop_duty3,
    client_value,
    client_fault,
    remote1_value,
    remote1_fault,
    bit_time_cyc,
    cpu_count,
    fan_out_one,
    fan_out_two,
    fan_out_three,
    remote1_reading,
    cpu_reading_first,
    cpu_low_limit_out,
    cpu_high_limit_out,
    swap_active,
    first_cpu_two_domains,
    smoothing_count_sel
);
    input wire core_clk;
    input wire rst_n;
    input wire [7:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata;
    input wire lock_bit;
    input wire offset64_sel;
    input wire [2:0] auto_mode;
    input wire [2:0] fan_startup;
    input wire [7:0] loop_duty1;
    input wire [7:0] loop_duty2;
    input wire [7:0] loop_duty3;
    input wire [7:0] client_value;
    input wire client_fault;
    input wire [7:0] remote1_value;
    input wire remote1_fault;
    input wire [7:0] bit_time_cyc;
    input wire [2:0] cpu_count;
    output wire [7:0] fan_out_one;
    output wire [7:0] fan_out_two;
    output wire [7:0] fan_out_three;
    output reg [7:0] remote1_reading;
    output reg [7:0] cpu_reading_first;
    output reg [7:0] cpu_low_limit_out;
    output reg [7:0] cpu_high_limit_out;
    output reg swap_active;
    output reg first_cpu_two_domains;
    output reg [2:0] smoothing_count_sel;

    localparam ST_IDLE = 2'b01;
    localparam ST_GAP = 2'b10;

    wire fault_s;
    wire rfault_s;
    wire [7:0] d1_rd;
    wire [7:0] d2_rd;
    wire [7:0] d3_rd;
    wire [7:0] c1_rd;
    wire [7:0] c2_rd;
    wire [7:0] c3_rd;
    wire [7:0] fault_code;
    wire [7:0] thermal_now;
    wire [7:0] remote_now;
    wire [2:0] startup_s;
    wire [15:0] read_cyc;
    // Full-width product; the slot count is kept below 16 bits by the user
    wire [31:0] read_cyc_full;
    wire [16:0] reads_needed;
    wire upd_pulse;

    reg [7:0] read0_r;
    reg [7:0] rem1_r;
    reg [7:0] lolim_r;
    reg [7:0] hilim_r;
    reg [7:0] cfg_r;
    reg [1:0] state_r;
    reg [15:0] cyc_r;
    reg [16:0] reads_r;
    reg lock_q_r;
    reg ofs_q_r;

    // Fault flags come from the sensor front end clock-free; synchronise
    fdr_sync2 u_sync_fault (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(client_fault),
        .dout(fault_s)
    );
    fdr_sync2 u_sync_rfault (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .din(remote1_fault),
        .dout(rfault_s)
    );

    assign startup_s = fan_startup;

    // R7: coding select
    assign fault_code = ofs_q_r ? `FDR_FAULT_OFS : `FDR_FAULT_TWOS;
    // R8: fault in twos coding; R9: fault in offset-64 coding
    assign thermal_now = fault_s ? fault_code : client_value;
    assign remote_now = rfault_s ? fault_code : remote1_value;

    // R10: one read = bit time x 67 x CPUs + idle gap
    assign read_cyc_full = bit_time_cyc * `FDR_BITS_PER_READ * cpu_count
        + `FDR_IDLE_CYC;
    assign read_cyc = read_cyc_full[15:0];

    // R11: 16 for code 0, else 2048 << (code-1)
    assign reads_needed = (cfg_r[2:0] == 3'h0) ?
        (17'h1 << `FDR_SMOOTH_LOG0) :
        (17'h1 << (`FDR_SMOOTH_LOG1 + cfg_r[2:0] - 3'h1));

    assign upd_pulse = (state_r == ST_GAP) && (cyc_r == 16'h0)
        && (reads_r + 17'h1 >= reads_needed);

    fdr_duty_chan u_ch1 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .auto_mode(auto_mode[0]),
        .startup(startup_s[0]),
        .loop_duty(loop_duty1),
        .wr_duty(reg_wr && reg_addr == `FDR_A_DUTY1),
        .wr_ceil(reg_wr && reg_addr == `FDR_A_CEIL1),
        .wdata(reg_wdata),
        .duty_rd(d1_rd),
        .ceil_rd(c1_rd),
        .duty_out(fan_out_one)
    );
    fdr_duty_chan u_ch2 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .auto_mode(auto_mode[1]),
        .startup(startup_s[1]),
        .loop_duty(loop_duty2),
        .wr_duty(reg_wr && reg_addr == `FDR_A_DUTY2),
        .wr_ceil(reg_wr && reg_addr == `FDR_A_CEIL2),
        .wdata(reg_wdata),
        .duty_rd(d2_rd),
        .ceil_rd(c2_rd),
        .duty_out(fan_out_two)
    );
    fdr_duty_chan u_ch3 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .auto_mode(auto_mode[2]),
        .startup(startup_s[2]),
        .loop_duty(loop_duty3),
        .wr_duty(reg_wr && reg_addr == `FDR_A_DUTY3),
        .wr_ceil(reg_wr && reg_addr == `FDR_A_CEIL3),
        .wdata(reg_wdata),
        .duty_rd(d3_rd),
        .ceil_rd(c3_rd),
        .duty_out(fan_out_three)
    );

    // Smoothing interval pacing
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cyc_r <= 16'h0;
            reads_r <= 17'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cyc_r <= read_cyc;
                    state_r <= ST_GAP;
                end
                ST_GAP: begin
                    if (cyc_r != 16'h0) begin
                        cyc_r <= cyc_r - 16'h1;
                    end else begin
                        state_r <= ST_IDLE;
                        if (upd_pulse) begin
                            reads_r <= 17'h0;
                        end else begin
                            reads_r <= reads_r + 17'h1;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            read0_r <= `FDR_RST_READ;
            rem1_r <= `FDR_RST_READ;
            lolim_r <= `FDR_RST_LOLIM;
            hilim_r <= `FDR_RST_HILIM;
            cfg_r <= `FDR_RST_CFG;
            lock_q_r <= 1'b0;
            ofs_q_r <= 1'b0;
        end else begin
            lock_q_r <= lock_bit;
            ofs_q_r <= offset64_sel;
            // R10: reading refreshed once per smoothing interval
            if (upd_pulse) begin
                read0_r <= thermal_now;
                rem1_r <= remote_now;
            end
            if (reg_wr && reg_addr == `FDR_A_LOLIM) begin
                lolim_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == `FDR_A_HILIM) begin
                hilim_r <= reg_wdata;
            end
            // R15: locked config ignores writes; reserved code kept out
            if (reg_wr && reg_addr == `FDR_A_CFG && !lock_q_r
                && reg_wdata[2:0] != `FDR_SMOOTH_RSVD) begin
                cfg_r <= reg_wdata & `FDR_CFG_WMASK;
            end
        end
    end

    // Registered outputs and read data
    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= `FDR_ZERO8;
            remote1_reading <= `FDR_RST_READ;
            cpu_reading_first <= `FDR_RST_READ;
            cpu_low_limit_out <= `FDR_RST_LOLIM;
            cpu_high_limit_out <= `FDR_RST_HILIM;
            swap_active <= 1'b0;
            first_cpu_two_domains <= 1'b0;
            smoothing_count_sel <= 3'h0;
        end else begin
            // R13: swap readings
            remote1_reading <= cfg_r[`FDR_CFG_SWAP] ? read0_r : rem1_r;
            cpu_reading_first <= cfg_r[`FDR_CFG_SWAP] ? rem1_r : read0_r;
            // R14: limits pass through unswapped; downstream fan loop uses flag
            cpu_low_limit_out <= lolim_r;
            cpu_high_limit_out <= hilim_r;
            swap_active <= cfg_r[`FDR_CFG_SWAP];
            // R12: domain count
            first_cpu_two_domains <= cfg_r[`FDR_CFG_DOM];
            smoothing_count_sel <=
                cfg_r[`FDR_CFG_SMOOTH_HI:`FDR_CFG_SMOOTH_LO];
            if (reg_rd) begin
                case (reg_addr)
                    `FDR_A_DUTY1: reg_rdata <= d1_rd;
                    `FDR_A_DUTY2: reg_rdata <= d2_rd;
                    `FDR_A_DUTY3: reg_rdata <= d3_rd;
                    // R6: read-only thermal reading
                    `FDR_A_READ0: reg_rdata <= cfg_r[`FDR_CFG_SWAP] ?
                        rem1_r : read0_r;
                    `FDR_A_LOLIM: reg_rdata <= lolim_r;
                    `FDR_A_HILIM: reg_rdata <= hilim_r;
                    `FDR_A_CFG: reg_rdata <= cfg_r;
                    `FDR_A_CEIL1: reg_rdata <= c1_rd;
                    `FDR_A_CEIL2: reg_rdata <= c2_rd;
                    `FDR_A_CEIL3: reg_rdata <= c3_rd;
                    default: reg_rdata <= `FDR_ZERO8;
                endcase
            end
        end
    end
endmodule

// ### verification/fdr_checker.sv
// Port checker for the fan duty and thermal register bank
`timescale 1ns/1ps
module fdr_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic lock_bit,
    input wire logic [2:0] auto_mode,
    input wire logic [2:0] fan_startup,
    input wire logic [7:0] loop_duty1,
    input wire logic [7:0] fan_out_one,
    input wire logic [7:0] cpu_reading_first,
    input wire logic [7:0] cpu_low_limit_out,
    input wire logic [7:0] cpu_high_limit_out,
    input wire logic swap_active,
    input wire logic first_cpu_two_domains,
    input wire logic [2:0] smoothing_count_sel
);
    logic [7:0] ceil_r;
    logic [7:0] ceil_d1_r;
    logic [7:0] ceil_d2_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Ceiling shadow, delayed two edges to match the min() output stage
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ceil_r <= 8'hff;
        end else if (reg_wr && reg_addr == 8'h38) begin
            ceil_r <= reg_wdata;
        end
        ceil_d1_r <= ceil_r;
        ceil_d2_r <= ceil_d1_r;
    end
    rst_vals_a: assert property (
        $rose(rst_n) |-> fan_out_one == 8'hff && cpu_reading_first == 8'h80
        && cpu_low_limit_out == 8'h81 && cpu_high_limit_out == 8'h00)
        else $error("Values after reset are wrong");
    rd_unmapped_a: assert property (
        reg_rd && (reg_addr < 8'h30 || reg_addr > 8'h3a || reg_addr == 8'h37)
        |=> reg_rdata == 8'h00)
        else $error("Unmapped read gave nonzero data");
    startup_read_a: assert property (
        reg_rd && reg_addr == 8'h30 && fan_startup[0] |=> reg_rdata == 8'h00)
        else $error("Duty read during startup not zero");
    reading_read_a: assert property (
        reg_rd && reg_addr == 8'h33 |=> reg_rdata == $past(cpu_reading_first))
        else $error("Reading register read differs from output");
    cfg_locked_a: assert property (
        lock_bit && $past(lock_bit) && reg_wr && reg_addr == 8'h36
        |=> $stable({swap_active, first_cpu_two_domains,
        smoothing_count_sel})[*2])
        else $error("Locked config changed");
    cfg_write_a: assert property (
        (reg_wr && reg_addr == 8'h36 && !$past(lock_bit)
        && reg_wdata[2:0] != 3'h7) ##1 (reg_rd && reg_addr == 8'h36)
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1f))
        else $error("Config readback wrong");
    manual_wr_a: assert property (
        (reg_wr && reg_addr == 8'h30 && !auto_mode[0]) ##1 (reg_rd
        && reg_addr == 8'h30 && !auto_mode[0] && !fan_startup[0])
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("Manual duty write not stored");
    auto_track_a: assert property (
        reg_rd && reg_addr == 8'h30 && auto_mode[0] && !fan_startup[0]
        && $stable(loop_duty1) && $stable(auto_mode)
        |=> reg_rdata == $past(loop_duty1))
        else $error("Auto duty does not follow loop");
    ceil_cap_a: assert property (
        ceil_r == ceil_d2_r |-> fan_out_one <= ceil_r)
        else $error("Fan output above ceiling");
endmodule
bind fdr_regs fdr_checker u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock_bit(lock_bit),
    .auto_mode(auto_mode), .fan_startup(fan_startup),
    .loop_duty1(loop_duty1), .fan_out_one(fan_out_one),
    .cpu_reading_first(cpu_reading_first),
    .cpu_low_limit_out(cpu_low_limit_out),
    .cpu_high_limit_out(cpu_high_limit_out), .swap_active(swap_active),
    .first_cpu_two_domains(first_cpu_two_domains),
    .smoothing_count_sel(smoothing_count_sel));

// ### verification/fdr_host.sv
// Register host model driving the bank's access strobes
`timescale 1ns/1ps
module fdr_host (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'hff;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Called 1 ns after an edge; strobes stand until the next call
    task automatic op(input logic w, input logic r, input logic [7:0] a,
        input logic [7:0] d);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        // Unused data lines toggle so stale values cannot pass
        reg_wdata = w ? d : ~reg_wdata;
        @(posedge core_clk);
        #1;
    endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the fan duty and thermal register bank
`timescale 1ns/1ps
module testbench;
    logic core_clk, rst_n, lock_bit, offset64_sel, client_fault;
    logic [2:0] auto_mode, fan_startup;
    logic [7:0] loop_duty1, loop_duty2, client_value, remote1_value;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fan_out_one, fan_out_three;
    logic [7:0] remote1_reading, cpu_reading_first, lo_out, hi_out;
    logic reg_wr, reg_rd, swap_active, two_dom;
    logic [2:0] smooth_sel;
    int fail_count, n_compared, i;
    fdr_host u_host (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    fdr_regs u_fdr_regs (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock_bit(lock_bit),
        .offset64_sel(offset64_sel), .auto_mode(auto_mode),
        .fan_startup(fan_startup), .loop_duty1(loop_duty1),
        .loop_duty2(loop_duty2), .loop_duty3(8'h00),
        .client_value(client_value), .client_fault(client_fault),
        .remote1_value(remote1_value), .remote1_fault(1'b0),
        .bit_time_cyc(8'h01), .cpu_count(3'h1), .fan_out_one(fan_out_one),
        .fan_out_two(), .fan_out_three(fan_out_three),
        .remote1_reading(remote1_reading),
        .cpu_reading_first(cpu_reading_first), .cpu_low_limit_out(lo_out),
        .cpu_high_limit_out(hi_out), .swap_active(swap_active),
        .first_cpu_two_domains(two_dom), .smoothing_count_sel(smooth_sel));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.op(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_host.op(1'b0, 1'b1, a, 8'h00);
        chk(reg_rdata, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) u_host.op(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        idle(5);
        rst_n = 1'b1;
    endtask
    function automatic logic [7:0] rst_exp(input logic [7:0] a);
        case (a)
            8'h33: return 8'h80;
            8'h34: return 8'h81;
            8'h35, 8'h36, 8'h37, 8'h3b: return 8'h00;
            default: return 8'hff;
        endcase
    endfunction
    task summarize;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge core_clk);
        fail_count++;
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        {lock_bit, offset64_sel, client_fault} = 3'h0;
        {auto_mode, fan_startup} = 6'h00;
        {loop_duty1, loop_duty2} = 16'h0000;
        client_value = 8'h3c;
        remote1_value = 8'h25;
        {fail_count, n_compared} = 0;
        do_reset();
        for (i = 8'h30; i < 8'h3c; i++) rd(i[7:0], rst_exp(i[7:0]));
        wr(8'h33, 8'h55);
        rd(8'h33, 8'h80);
        auto_mode = 3'b001;
        loop_duty1 = 8'h66;
        wr(8'h30, 8'h11);
        rd(8'h30, 8'h66);
        fan_startup = 3'b001;
        rd(8'h30, 8'h00);
        fan_startup = 3'b000;
        idle(1);
        chk(fan_out_one, 8'h66);
        auto_mode = 3'b000;
        wr(8'h30, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h31, 8'hff);
        rd(8'h31, 8'hff);
        wr(8'h32, 8'h40);
        idle(2);
        chk(fan_out_one, 8'h00);
        chk(fan_out_three, 8'h40);
        wr(8'h3a, 8'h20);
        idle(2);
        chk(fan_out_three, 8'h20);
        rd(8'h32, 8'h40);
        wr(8'h34, 8'h12);
        wr(8'h35, 8'h7e);
        idle(2);
        chk(lo_out, 8'h12);
        chk(hi_out, 8'h7e);
        for (i = 0; i < 7; i++) begin
            wr(8'h36, i[7:0]);
            rd(8'h36, i[7:0]);
        end
        wr(8'h36, 8'hff);
        rd(8'h36, 8'h06);
        wr(8'h36, 8'h08);
        idle(2);
        chk({7'h00, two_dom}, 8'h01);
        lock_bit = 1'b1;
        idle(1);
        wr(8'h36, 8'h05);
        rd(8'h36, 8'h08);
        lock_bit = 1'b0;
        do_reset();
        idle(3000);
        chk(cpu_reading_first, 8'h80);
        idle(600);
        chk(cpu_reading_first, 8'h3c);
        chk(remote1_reading, 8'h25);
        wr(8'h36, 8'h10);
        idle(3400);
        chk(cpu_reading_first, 8'h25);
        chk(remote1_reading, 8'h3c);
        wr(8'h36, 8'h00);
        client_fault = 1'b1;
        offset64_sel = 1'b1;
        idle(3400);
        chk(cpu_reading_first, 8'h00);
        offset64_sel = 1'b0;
        idle(3400);
        chk(cpu_reading_first, 8'h80);
        summarize();
    end
endmodule
